/* File: rtac_defs.svh */
`ifndef RTAC_DEFS_SVH
`define RTAC_DEFS_SVH
// Summary of operation
// - alerts are a ring indication or characters 07h then 12h on a port
// - line speed and feature switches sampled on console boot or any ring
// - port feature switch sampled again when first alert character arrives
// - remote boot from either port; password on port 1 only
// - feature switch disabled blocks auto-answer; messages-only lets host answer
// - boot settings give host two rings to raise DTR, then device answers
// - after device answers, host is shut out until the session ends (access-denied, quit, boot or end)
// - power password holds 1 to 15 characters and is compared on entry
// - each port 1 ring during a port 1 session starts a fresh session needing passwords again
// - wrong password retries; third failure denies access and drops RTS, DTR
// - port 0 powers on and boots freely; power-down always needs password
// - password set only from console or port 0 boot display
// - port 1 ring with power on waits five seconds, then answers and prompts
// - power off asks to power on, waits ten seconds, anything but Y on a boot-and-power port ends
// - power-up not complete in thirty seconds reports failure and ends
// - first alert suspends host, flags, messages, waits ten seconds for second
// - second alert takes the port from host and, on port 1, prompts for boot password
// - second alert watched only after message sent; earlier characters dropped
// - power-off with good password opens relay, reports start and completion
// - accepted boot password not asked again until a port 1 ring or session end (access-denied, quit, boot or end); power-down password asked every time

// ==================== characters and limits ====================
`define RTAC_CHR_ALERT1 8'h07
`define RTAC_CHR_ALERT2 8'h12
`define RTAC_CHR_YES 8'h59
`define RTAC_CHR_CR 8'h0D
`define RTAC_RING_LIMIT 2'h2
`define RTAC_TRY_LIMIT 2'h3
`define RTAC_PW_MAX 4'hF

// ==================== timing ====================
`define RTAC_CLK_PERIOD_NS 25
`define RTAC_TICK_MS 1
`define RTAC_TICK_CYCLES ((`RTAC_TICK_MS * 1000000) / `RTAC_CLK_PERIOD_NS)
`define RTAC_HOST_WAIT_S 5
`define RTAC_ALERT_WAIT_S 10
`define RTAC_REPLY_WAIT_S 10
`define RTAC_PWR_UP_WAIT_S 30
`define RTAC_S_TO_TICKS(s) ((s) * 1000 / `RTAC_TICK_MS)

// ==================== register map ====================
`define RTAC_OFF_CMD 12'h000
`define RTAC_OFF_STATUS 12'h004
`define RTAC_OFF_PW 12'h008
`define RTAC_CMD_QUIT 0
`define RTAC_CMD_SHORT_BOOT 1
`define RTAC_CMD_LONG_BOOT 2
`define RTAC_CMD_OFF_PWR 3
`define RTAC_CMD_CONSOLE_BOOT 4
`define RTAC_PW_SEL_BIT 16
`define RTAC_PW_SRC_BIT 17
`endif

/* File: rtac_pkg.sv */
package rtac_pkg;
  // session sequencer states, one-hot
  typedef enum logic [11:0] {
    S_IDLE = 12'h001,
    S_HOST_WAIT = 12'h002,
    S_MSG = 12'h004,
    S_BOOT_PW = 12'h008,
    S_YN_WAIT = 12'h010,
    S_PWR_PW = 12'h020,
    S_PWR_UP = 12'h040,
    S_DISPLAY = 12'h080,
    S_ALERT_WAIT = 12'h100,
    S_OFF_PW = 12'h200,
    S_PWR_DOWN = 12'h400,
    S_END = 12'h800
  } rtac_state_type;

  // port feature switch positions
  typedef enum logic [1:0] {
    FEAT_DISABLED = 2'h0,
    FEAT_MESSAGES_ONLY_SETTING = 2'h1,
    FEAT_BOOT = 2'h2,
    FEAT_BOOT_PWR = 2'h3
  } rtac_feat_type;

  // messages handed to the port transmitter
  typedef enum logic [3:0] {
    MSG_NONE = 4'h0,
    MSG_ENTER_BOOT_PW = 4'h1,
    MSG_ASK_POWER_ON = 4'h2,
    MSG_ENTER_PWR_PW = 4'h3,
    MSG_PWR_UP_INIT = 4'h4,
    MSG_PWR_STILL_OFF = 4'h5,
    MSG_ACCESS_ENABLED = 4'h6,
    MSG_ACCESS_DISABLED = 4'h7,
    MSG_RETRY = 4'h8,
    MSG_ACCESS_DENIED = 4'h9,
    MSG_PWR_DOWN_INIT = 4'hA,
    MSG_PWR_IS_OFF = 4'hB,
    MSG_CLEAR_SCREEN = 4'hC
  } rtac_msg_type;
endpackage : rtac_pkg

/* File: rtac_access_ctrl.sv */
`timescale 1ns/100ps
`include "rtac_defs.svh"
module rtac_access_ctrl #(
  parameter int TICK_CYCLES = `RTAC_TICK_CYCLES,
  parameter int HOST_WAIT_TICKS = `RTAC_S_TO_TICKS(`RTAC_HOST_WAIT_S),
  parameter int ALERT_WAIT_TICKS = `RTAC_S_TO_TICKS(`RTAC_ALERT_WAIT_S),
  parameter int REPLY_WAIT_TICKS = `RTAC_S_TO_TICKS(`RTAC_REPLY_WAIT_S),
  parameter int PWR_UP_WAIT_TICKS = `RTAC_S_TO_TICKS(`RTAC_PWR_UP_WAIT_S)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] ring_ind,
  input wire logic [1:0] feat_sw0,
  input wire logic [1:0] feat_sw1,
  input wire logic [7:0] line_speed_sw,
  input wire logic console_boot_n,
  input wire logic power_good,
  input wire logic [1:0] host_dtr_req,
  input wire logic [1:0] rx_valid,
  input wire logic [7:0] rx_char0,
  input wire logic [7:0] rx_char1,
  input wire logic msg_done,
  output logic msg_req,
  output rtac_pkg::rtac_msg_type msg_code,
  output logic msg_port,
  output logic [1:0] dtr,
  output logic [1:0] rts,
  output logic [1:0] host_block,
  output logic alert_flag,
  output logic relay_on,
  output logic display_on
);
  import rtac_pkg::*;

  // elaboration check: tick and wait counters are 16 bits, so every count must fit
  if (TICK_CYCLES < 2 || TICK_CYCLES > 65535 || HOST_WAIT_TICKS < 1 || HOST_WAIT_TICKS > 65535 ||
      ALERT_WAIT_TICKS < 1 || ALERT_WAIT_TICKS > 65535 || REPLY_WAIT_TICKS < 1 || REPLY_WAIT_TICKS > 65535 ||
      PWR_UP_WAIT_TICKS < 1 || PWR_UP_WAIT_TICKS > 65535) begin : g_bad_timing
    $error("rtac_access_ctrl: timing parameters out of range");
  end

  // ==================== pin synchronisers ====================
  // pins cross in through two flops; ring edge compares the second stage with a third flop
  logic [13:0] s1_reg, s1_next, s2_reg, s2_next;
  logic [2:0] edge_reg, edge_next;
  logic [1:0] ring_rise;
  logic boot_fall;
  always_comb begin
    s1_next = {ring_ind, feat_sw0, feat_sw1, line_speed_sw};
    s2_next = s1_reg;
    edge_next = {s2_reg[13:12], m2_reg[1]};
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= 14'h0000;
      s2_reg <= 14'h0000;
      edge_reg <= 3'h1;
    end else if (clk_en) begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      edge_reg <= edge_next;
    end
  end
  logic [1:0] m1_reg, m2_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      m1_reg <= 2'h3;
      m2_reg <= 2'h3;
    end else if (clk_en) begin
      m1_reg <= {console_boot_n, power_good};
      m2_reg <= m1_reg;
    end
  end
  assign ring_rise = s2_reg[13:12] & ~edge_reg[2:1];
  assign boot_fall = ~m2_reg[1] & edge_reg[0];

  // ==================== password compare ====================
  function automatic logic pw_ok(input logic [3:0] len, input logic [3:0] idx, input logic miss);
    pw_ok = !miss && (idx == len) && (len != 4'h0);
  endfunction : pw_ok

  // ==================== state ====================
  rtac_state_type state_reg, state_next, ret_reg, ret_next;
  logic port_reg, port_next;
  logic [1:0] tries_reg, tries_next, rings_reg, rings_next;
  logic [3:0] idx_reg, idx_next;
  logic miss_reg, miss_next, boot_ok_reg, boot_ok_next, pwr_ok_reg, pwr_ok_next;
  logic alert_reg, alert_next, relay_reg, relay_next, disp_reg, disp_next;
  logic [1:0] block_reg, block_next, dtr_reg, dtr_next, rts_reg, rts_next;
  logic msg_req_reg, msg_req_next, msg_port_reg, msg_port_next;
  rtac_msg_type msg_code_reg, msg_code_next;
  logic [7:0] speed_reg, speed_next;
  logic [1:0] feat0_reg, feat0_next, feat1_reg, feat1_next;
  logic [15:0] tick_reg, tick_next, wait_reg, wait_next;
  logic [7:0] boot_pw_reg [15], boot_pw_next [15], pwr_pw_reg [15], pwr_pw_next [15];
  logic [3:0] boot_len_reg, boot_len_next, pwr_len_reg, pwr_len_next;
  logic pw_rej_reg, pw_rej_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;

  // ==================== next-state logic ====================
  logic rx_hit, go_msg, end_sess, wr_now;
  logic [7:0] rx_c;
  logic [3:0] pw_len;
  logic [7:0] pw_chr;
  rtac_msg_type go_code;
  rtac_state_type go_ret;
  rtac_feat_type feat_cur;
  always_comb begin
    state_next = state_reg;
    ret_next = ret_reg;
    port_next = port_reg;
    tries_next = tries_reg;
    rings_next = rings_reg;
    idx_next = idx_reg;
    miss_next = miss_reg;
    boot_ok_next = boot_ok_reg;
    pwr_ok_next = pwr_ok_reg;
    alert_next = alert_reg;
    relay_next = relay_reg;
    disp_next = disp_reg;
    block_next = block_reg;
    dtr_next = dtr_reg;
    rts_next = rts_reg;
    msg_req_next = msg_req_reg;
    msg_port_next = msg_port_reg;
    msg_code_next = msg_code_reg;
    speed_next = speed_reg;
    feat0_next = feat0_reg;
    feat1_next = feat1_reg;
    boot_pw_next = boot_pw_reg;
    pwr_pw_next = pwr_pw_reg;
    boot_len_next = boot_len_reg;
    pwr_len_next = pwr_len_reg;
    pw_rej_next = pw_rej_reg;
    prdata_next = prdata_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    go_msg = 1'b0;
    go_code = MSG_NONE;
    go_ret = S_IDLE;
    end_sess = 1'b0;
    wr_now = psel && penable && !pready_reg && pwrite;
    rx_hit = rx_valid[port_reg];
    rx_c = port_reg ? rx_char1 : rx_char0;
    feat_cur = rtac_feat_type'(port_reg ? feat1_reg : feat0_reg);
    pw_len = pwr_len_reg;
    pw_chr = rx_c;

    tick_next = (tick_reg == 16'(TICK_CYCLES - 1)) ? 16'h0000 : tick_reg + 16'h0001;
    wait_next = (tick_reg == 16'(TICK_CYCLES - 1)) ? wait_reg + 16'h0001 : wait_reg;

    if (boot_fall || (ring_rise != 2'h0)) begin
      speed_next = s2_reg[7:0];
      feat0_next = s2_reg[11:10];
      feat1_next = s2_reg[9:8];
    end

    // apb slave, one wait state
    if (psel && penable && !pready_reg) begin
      pready_next = 1'b1;
      if (paddr == `RTAC_OFF_STATUS) begin
        prdata_next = {1'b0, tries_reg, feat1_reg, feat0_reg, speed_reg, pw_rej_reg, relay_reg,
                       m2_reg[0], alert_reg, port_reg, state_reg};
      end else if (paddr == `RTAC_OFF_CMD || paddr == `RTAC_OFF_PW) begin
        prdata_next = 32'h00000000;
      end else begin
        prdata_next = 32'h00000000;
        pslverr_next = 1'b1;
      end
    end

    if (wr_now && paddr == `RTAC_OFF_PW) begin
      if ((!pwdata[`RTAC_PW_SRC_BIT] || (state_reg == S_DISPLAY && !port_reg)) && pwdata[15:12] != 4'h0 &&
          pwdata[11:8] < pwdata[15:12]) begin
        pw_rej_next = 1'b0;
        if (pwdata[`RTAC_PW_SEL_BIT]) begin
          pwr_pw_next[pwdata[11:8]] = pwdata[7:0];
          pwr_len_next = pwdata[15:12];
        end else begin
          boot_pw_next[pwdata[11:8]] = pwdata[7:0];
          boot_len_next = pwdata[15:12];
        end
      end else begin
        pw_rej_next = 1'b1;
      end
    end

    case (state_reg)
      S_IDLE: begin
        rings_next = 2'h0;
        if (ring_rise[1] && s2_reg[9:8] != FEAT_DISABLED) begin
          port_next = 1'b1;
          state_next = S_HOST_WAIT;
        end else if (ring_rise[0] && s2_reg[11:10] != FEAT_DISABLED) begin
          port_next = 1'b0;
          state_next = S_HOST_WAIT;
        end else if ((rx_valid[0] && rx_char0 == `RTAC_CHR_ALERT1) ||
                     (rx_valid[1] && rx_char1 == `RTAC_CHR_ALERT1)) begin
          port_next = !(rx_valid[0] && rx_char0 == `RTAC_CHR_ALERT1);
          if (rx_valid[0] && rx_char0 == `RTAC_CHR_ALERT1) begin
            feat0_next = s2_reg[11:10];
          end else begin
            feat1_next = s2_reg[9:8];
          end
          if ((port_next ? s2_reg[9:8] : s2_reg[11:10]) < FEAT_BOOT) begin
            go_msg = 1'b1;
            go_code = MSG_ACCESS_DISABLED;
          end else begin
            alert_next = 1'b1;
            block_next = 2'h3;
            go_msg = 1'b1;
            go_code = MSG_ACCESS_ENABLED;
            go_ret = S_ALERT_WAIT;
          end
        end
      end
      S_HOST_WAIT: begin
        if (ring_rise[port_reg]) begin
          rings_next = rings_reg + 2'h1;
        end
        if (host_dtr_req[port_reg]) begin
          state_next = S_IDLE;
        end else if (feat_cur >= FEAT_BOOT && (rings_reg == `RTAC_RING_LIMIT ||
                     (m2_reg[0] && wait_reg >= 16'(HOST_WAIT_TICKS)))) begin
          dtr_next[port_reg] = 1'b1;
          rts_next[port_reg] = 1'b1;
          block_next[port_reg] = 1'b1;
          state_next = S_DISPLAY;
          boot_ok_next = 1'b0;
          pwr_ok_next = 1'b0;
          tries_next = 2'h0;
        end
        if (state_next == S_DISPLAY) begin
          if (port_reg) begin
            go_msg = 1'b1;
            go_code = MSG_ENTER_BOOT_PW;
            go_ret = S_BOOT_PW;
          end else if (!m2_reg[0]) begin
            go_msg = 1'b1;
            go_code = MSG_ASK_POWER_ON;
            go_ret = S_YN_WAIT;
          end
        end
      end
      S_MSG: begin
        if (msg_done) begin
          msg_req_next = 1'b0;
          state_next = ret_reg;
          if (msg_code_reg == MSG_ACCESS_DENIED || ret_reg == S_END) begin
            end_sess = 1'b1;
          end
        end
      end
      S_BOOT_PW, S_PWR_PW, S_OFF_PW: begin
        if (state_reg == S_BOOT_PW) begin
          pw_len = boot_len_reg;
          pw_chr = boot_pw_reg[idx_reg];
        end else begin
          pw_chr = pwr_pw_reg[idx_reg];
        end
        if (rx_hit && rx_c == `RTAC_CHR_CR) begin
          idx_next = 4'h0;
          miss_next = 1'b0;
          if (pw_ok(pw_len, idx_reg, miss_reg)) begin
            tries_next = 2'h0;
            if (state_reg == S_BOOT_PW) begin
              boot_ok_next = 1'b1;
              state_next = S_DISPLAY;
              if (!m2_reg[0]) begin
                go_msg = 1'b1;
                go_code = MSG_ASK_POWER_ON;
                go_ret = S_YN_WAIT;
              end
            end else if (state_reg == S_PWR_PW) begin
              pwr_ok_next = 1'b1;
              relay_next = 1'b1;
              go_msg = 1'b1;
              go_code = MSG_PWR_UP_INIT;
              go_ret = S_PWR_UP;
            end else begin
              pwr_ok_next = 1'b1;
              relay_next = 1'b0;
              go_msg = 1'b1;
              go_code = MSG_PWR_DOWN_INIT;
              go_ret = S_PWR_DOWN;
            end
          end else if (tries_reg == `RTAC_TRY_LIMIT - 2'h1) begin
            go_msg = 1'b1;
            go_code = MSG_ACCESS_DENIED;
            go_ret = S_IDLE;
          end else begin
            tries_next = tries_reg + 2'h1;
            go_msg = 1'b1;
            go_code = MSG_RETRY;
            go_ret = state_reg;
          end
        end else if (rx_hit) begin
          miss_next = miss_reg || idx_reg == `RTAC_PW_MAX || rx_c != pw_chr;
          idx_next = (idx_reg == `RTAC_PW_MAX) ? idx_reg : idx_reg + 4'h1;
        end
      end
      S_YN_WAIT: begin
        if (rx_hit && rx_c == `RTAC_CHR_YES && feat_cur == FEAT_BOOT_PWR) begin
          if (port_reg && !pwr_ok_reg) begin
            go_msg = 1'b1;
            go_code = MSG_ENTER_PWR_PW;
            go_ret = S_PWR_PW;
          end else begin
            relay_next = 1'b1;
            go_msg = 1'b1;
            go_code = MSG_PWR_UP_INIT;
            go_ret = S_PWR_UP;
          end
        end else if (rx_hit || wait_reg >= 16'(REPLY_WAIT_TICKS)) begin
          go_msg = 1'b1;
          go_code = MSG_CLEAR_SCREEN;
          go_ret = S_END;
        end
      end
      S_PWR_UP: begin
        if (m2_reg[0]) begin
          state_next = S_DISPLAY;
        end else if (wait_reg >= 16'(PWR_UP_WAIT_TICKS)) begin
          relay_next = 1'b0;
          go_msg = 1'b1;
          go_code = MSG_PWR_STILL_OFF;
          go_ret = S_END;
        end
      end
      S_PWR_DOWN: begin
        if (!m2_reg[0]) begin
          go_msg = 1'b1;
          go_code = MSG_PWR_IS_OFF;
          go_ret = S_DISPLAY;
        end
      end
      S_ALERT_WAIT: begin
        if (rx_valid[port_reg] && rx_c == `RTAC_CHR_ALERT2) begin
          block_next = 2'h0;
          block_next[port_reg] = 1'b1;
          dtr_next[port_reg] = 1'b1;
          rts_next[port_reg] = 1'b1;
          tries_next = 2'h0;
          state_next = S_DISPLAY;
          if (port_reg && !boot_ok_reg) begin
            go_msg = 1'b1;
            go_code = MSG_ENTER_BOOT_PW;
            go_ret = S_BOOT_PW;
          end
        end else if (wait_reg >= 16'(ALERT_WAIT_TICKS)) begin
          alert_next = 1'b0;
          block_next = 2'h0;
          state_next = S_IDLE;
        end
      end
      S_DISPLAY: begin
        disp_next = 1'b1;
        if (wr_now && paddr == `RTAC_OFF_CMD && pwdata[`RTAC_CMD_OFF_PWR]) begin
          go_msg = 1'b1;
          go_code = MSG_ENTER_PWR_PW;
          go_ret = S_OFF_PW;
        end
      end
      default: begin
        end_sess = 1'b1;
      end
    endcase

    if (state_reg != S_IDLE && state_reg != S_HOST_WAIT && wr_now && paddr == `RTAC_OFF_CMD &&
        (pwdata[`RTAC_CMD_QUIT] || pwdata[`RTAC_CMD_SHORT_BOOT] || pwdata[`RTAC_CMD_LONG_BOOT])) begin
      end_sess = 1'b1;
      go_msg = 1'b0;
    end
    if (go_msg) begin
      msg_req_next = 1'b1;
      msg_code_next = go_code;
      msg_port_next = port_next;
      ret_next = go_ret;
      state_next = S_MSG;
    end
    if (end_sess) begin
      state_next = S_IDLE;
      dtr_next = 2'h0;
      rts_next = 2'h0;
      block_next = 2'h0;
      alert_next = 1'b0;
      disp_next = 1'b0;
      boot_ok_next = 1'b0;
      pwr_ok_next = 1'b0;
      msg_req_next = 1'b0;
    end
    if (ring_rise[1] && port_reg && state_reg != S_IDLE && state_reg != S_HOST_WAIT && !end_sess) begin
      boot_ok_next = 1'b0;
      pwr_ok_next = 1'b0;
      disp_next = 1'b0;
      tries_next = 2'h0;
      msg_req_next = 1'b1;
      msg_code_next = MSG_ENTER_BOOT_PW;
      msg_port_next = 1'b1;
      ret_next = S_BOOT_PW;
      state_next = S_MSG;
    end
    if (state_next != state_reg) begin
      tick_next = 16'h0000;
      wait_next = 16'h0000;
      idx_next = 4'h0;
      miss_next = 1'b0;
    end
  end

  // ==================== registers ====================
  // password storage has no reset; contents mean nothing until a length is loaded
  always_ff @(posedge clk) begin
    if (clk_en) begin
      boot_pw_reg <= boot_pw_next;
      pwr_pw_reg <= pwr_pw_next;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= S_IDLE;
      ret_reg <= S_IDLE;
      port_reg <= 1'b0;
      tries_reg <= 2'h0;
      rings_reg <= 2'h0;
      idx_reg <= 4'h0;
      miss_reg <= 1'b0;
      boot_ok_reg <= 1'b0;
      pwr_ok_reg <= 1'b0;
      alert_reg <= 1'b0;
      relay_reg <= 1'b0;
      disp_reg <= 1'b0;
      block_reg <= 2'h0;
      dtr_reg <= 2'h0;
      rts_reg <= 2'h0;
      msg_req_reg <= 1'b0;
      msg_port_reg <= 1'b0;
      msg_code_reg <= MSG_NONE;
      speed_reg <= 8'h00;
      feat0_reg <= 2'h0;
      feat1_reg <= 2'h0;
      tick_reg <= 16'h0000;
      wait_reg <= 16'h0000;
      boot_len_reg <= 4'h0;
      pwr_len_reg <= 4'h0;
      pw_rej_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      ret_reg <= ret_next;
      port_reg <= port_next;
      tries_reg <= tries_next;
      rings_reg <= rings_next;
      idx_reg <= idx_next;
      miss_reg <= miss_next;
      boot_ok_reg <= boot_ok_next;
      pwr_ok_reg <= pwr_ok_next;
      alert_reg <= alert_next;
      relay_reg <= relay_next;
      disp_reg <= disp_next;
      block_reg <= block_next;
      dtr_reg <= dtr_next;
      rts_reg <= rts_next;
      msg_req_reg <= msg_req_next;
      msg_port_reg <= msg_port_next;
      msg_code_reg <= msg_code_next;
      speed_reg <= speed_next;
      feat0_reg <= feat0_next;
      feat1_reg <= feat1_next;
      tick_reg <= tick_next;
      wait_reg <= wait_next;
      boot_len_reg <= boot_len_next;
      pwr_len_reg <= pwr_len_next;
      pw_rej_reg <= pw_rej_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // outputs straight from flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign msg_req = msg_req_reg;
  assign msg_code = msg_code_reg;
  assign msg_port = msg_port_reg;
  assign dtr = dtr_reg;
  assign rts = rts_reg;
  assign host_block = block_reg;
  assign alert_flag = alert_reg;
  assign relay_on = relay_reg;
  assign display_on = disp_reg;
endmodule : rtac_access_ctrl

/* File: rtac_access_ctrl_monitor.sv */
`timescale 1ns/100ps
module rtac_access_ctrl_monitor (
  input logic clk,
  input logic rst,
  input logic psel,
  input logic penable,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic msg_done,
  input logic msg_req,
  input rtac_pkg::rtac_msg_type msg_code,
  input logic [1:0] dtr,
  input logic [1:0] host_block,
  input logic alert_flag
);
  import rtac_pkg::*;
  // =====
  // port checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // one wait state, one-cycle answer
  a_apb_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("late answer");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("long answer");
  a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("error data");
  // message stands until the sender is done
  a_msg_held: assert property (msg_req && !msg_done |=> msg_req && $stable(msg_code))
    else $error("message lost");
  a_msg_freed: assert property (msg_req && msg_done |=> !msg_req)
    else $error("message stuck");
  // first alert holds off the host; denied access drops DTR
  a_alert_block: assert property ($rose(alert_flag) |-> host_block == 2'h3)
    else $error("host not held");
  a_alert_msg: assert property ($rose(alert_flag) |-> ##[0:2] msg_code == MSG_ACCESS_ENABLED)
    else $error("no alert message");
  a_deny_drop: assert property (msg_req && msg_done && msg_code == MSG_ACCESS_DENIED
    |=> ##[0:2] dtr == 2'h0)
    else $error("line kept");
endmodule : rtac_access_ctrl_monitor
bind rtac_access_ctrl rtac_access_ctrl_monitor rtac_access_ctrl_monitor_i (.*);

/* File: rtac_term_model.sv */
`timescale 1ns/100ps
module rtac_term_model (
  input wire logic clk,
  input wire logic msg_req,
  input wire logic slow,
  output logic msg_done
);
  logic [3:0] cnt_reg;
  // =====
  // terminal transmitter
  // framing taken as agreed
  always @(posedge clk) begin
    msg_done <= 1'b0;
    if (!msg_req || msg_done)
      cnt_reg <= 4'h0;
    else if (cnt_reg == (slow ? 4'hC : 4'h2))
      msg_done <= 1'b1;
    else
      cnt_reg <= cnt_reg + 4'h1;
  end
endmodule : rtac_term_model

/* File: tb_remote_terminal_access_control.sv */
`timescale 1ns/100ps
module tb_remote_terminal_access_control;
  import rtac_pkg::*;
  // =====
  // bench signals
  logic clk = 1'b0, rst = 1'b1, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b1;
  logic console_boot_n = 1'b1, power_good = 1'b1, err, pready, pslverr, msg_done, msg_req, msg_port;
  logic alert_flag, relay_on, display_on;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0] ring_ind = 2'h0, feat_sw0 = 2'h3, feat_sw1 = 2'h0, host_dtr_req = 2'h0, rx_valid = 2'h0;
  logic [1:0] dtr, rts, host_block;
  logic [7:0] line_speed_sw = 8'hA5, rx_char0 = 8'hFF, rx_char1 = 8'hFF;
  rtac_msg_type msg_code;
  int n_fail = 0, comparisons = 0;
  // short tick, host and alert waits so those fit the run; reply and power-up waits keep defaults
  rtac_access_ctrl #(.TICK_CYCLES(4), .HOST_WAIT_TICKS(5), .ALERT_WAIT_TICKS(10)) rtac_access_ctrl_i (.*);
  rtac_term_model rtac_term_model_i (.*);
  // 40 MHz
  initial forever #12.5 clk = ~clk;
  // =====
  // helpers
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // apb cycle, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
    chk("pready", pready, 1'b1);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
    // one idle edge so a following call never drives psel twice in a step
    @(posedge clk);
  endtask : apb
  // idle data shows the inverse, not a stale char
  // char taken only with its valid
  task automatic send(input logic p, input logic [7:0] c);
    rx_valid <= 2'h1 << p;
    {rx_char0, rx_char1} <= {c, c};
    @(posedge clk);
    rx_valid <= 2'h0;
    {rx_char0, rx_char1} <= ~{c, c};
    repeat (3) @(posedge clk);
  endtask : send
  task automatic ring(input logic p);
    ring_ind <= 2'h1 << p;
    repeat (4) @(posedge clk);
    ring_ind <= 2'h0;
    repeat (4) @(posedge clk);
  endtask : ring
  task automatic msg(input rtac_msg_type code);
    int n;
    for (n = 0; n < 400 && (msg_req & msg_done) !== 1'b1; n++) @(posedge clk);
    chk("msg", {msg_req & msg_done, msg_code}, {1'b1, code});
    @(posedge clk);
  endtask : msg
  task automatic complete_run();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // =====
  // tests
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, 12'h004, 32'h0);
    chk("state", rd[11:0], 12'h001);
    apb(1'b0, 12'hFFC, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, 12'h008, 32'h0003_1041);
    apb(1'b0, 12'h004, 32'h0);
    chk("pw_rej", rd[16], 1'b1);
    repeat (3) ring(1'b1);
    chk("dtr", dtr, 2'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk("speed", rd[24:17], 8'hA5);
    {line_speed_sw, console_boot_n} <= {8'h3C, 1'b0};
    repeat (4) @(posedge clk);
    console_boot_n <= 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    chk("boot_speed", rd[24:17], 8'h3C);
    feat_sw1 <= 2'h2;
    repeat (3) ring(1'b1);
    msg(MSG_ENTER_BOOT_PW);
    chk("answer", {host_block, dtr, rts, msg_port}, 7'h55);
    for (int i = 0; i < 3; i++) begin
      send(1'b1, 8'h58);
      send(1'b1, 8'h0D);
      msg(i < 2 ? MSG_RETRY : MSG_ACCESS_DENIED);
    end
    repeat (3) @(posedge clk);
    chk("dropped", dtr, 2'h0);
    send(1'b0, 8'h07);
    chk("alert", {alert_flag, host_block}, 3'h7);
    send(1'b0, 8'h12);
    msg(MSG_ACCESS_ENABLED);
    chk("early", host_block, 2'h3);
    send(1'b0, 8'h12);
    chk("taken", {host_block, dtr, rts, display_on}, 7'h2B);
    apb(1'b0, 12'h004, 32'h0);
    chk("display", rd[11:0], 12'h080);
    apb(1'b1, 12'h000, 32'h1);
    repeat (20) @(posedge clk);
    send(1'b0, 8'h07);
    msg(MSG_ACCESS_ENABLED);
    repeat (50) @(posedge clk);
    chk("expired", {alert_flag, host_block}, 3'h0);
    feat_sw0 <= 2'h1;
    repeat (3) @(posedge clk);
    send(1'b0, 8'h07);
    msg(MSG_ACCESS_DISABLED);
    // port 0 with power off: ask, power up, load password, power down
    {feat_sw0, power_good} <= 3'h6;
    repeat (3) ring(1'b0);
    msg(MSG_ASK_POWER_ON);
    send(1'b0, 8'h59);
    msg(MSG_PWR_UP_INIT);
    chk("relay_up", relay_on, 1'b1);
    power_good <= 1'b1;
    repeat (6) @(posedge clk);
    apb(1'b1, 12'h008, 32'h0003_104B);
    apb(1'b0, 12'h004, 32'h0);
    chk("pw_load", {rd[16], rd[11:0]}, 13'h0080);
    apb(1'b1, 12'h000, 32'h8);
    msg(MSG_ENTER_PWR_PW);
    send(1'b0, 8'h4B);
    send(1'b0, 8'h0D);
    msg(MSG_PWR_DOWN_INIT);
    chk("relay_down", relay_on, 1'b0);
    power_good <= 1'b0;
    msg(MSG_PWR_IS_OFF);
    complete_run();
  end
  // hang guard, well past the expected run
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end
endmodule : tb_remote_terminal_access_control
